// >>> design/shift_and_bit_clear_unit.v
// execution datapath for arithmetic shift right and bit clear
`timescale 1ns/1ns
`include "shift_clear_defines.vh"
module shift_and_bit_clear_unit #(
  parameter SFR_WAIT = `SFR_WAIT_CYCLES
) (
  input wire ref_clk,
  input wire rst,
  input wire start,
  input wire [2:0] op_code,
  input wire byte_size,
  input wire to_work_reg,
  input wire [12:0] file_addr,
  input wire is_periph_sfr,
  input wire [3:0] bit_position_field,
  input wire [3:0] shift_count_literal,
  input wire [15:0] operand_in,
  input wire [15:0] default_work_register,
  input wire [15:0] base_operand_register,
  input wire [15:0] shift_amount_reg,
  output reg [15:0] result_q,
  output reg write_file_q,
  output reg write_work_q,
  output reg write_dest_q,
  output reg done_q,
  output reg addr_error_q,
  output reg busy_q,
  output reg flag_n_q,
  output reg flag_z_q,
  output reg flag_c_q,
  output reg flags_we_q,
  output reg carry_we_q
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function [15:0] bit_mask;
    input [3:0] pos;
    input sz;
    begin
      bit_mask = 16'h0001 << (sz ? {1'b0, pos[2:0]} : pos);
    end
  endfunction
  function [15:0] asr_word;
    input [15:0] v;
    input [4:0] n;
    begin
      asr_word = $signed(v) >>> n;
    end
  endfunction

  // only the file forms can hit a slow peripheral register
  function is_file_op;
    input [2:0] op;
    begin
      is_file_op = (op == `OP_ASR_FILE) || (op == `OP_SINGLE_BIT_CLEAR_OP_FILE);
    end
  endfunction

  reg [15:0] src;
  reg [15:0] res_d;
  reg c_d;
  reg cw_d;
  reg fw_d;
  reg bad_d;
  reg [4:0] amt;
  wire fn;
  wire fz;
  reg [1:0] state_q;
  reg [7:0] wait_q;
  reg wait_asr_q;
  reg wait_to_work_q;
  localparam IDLE = 2'b00;
  localparam WAIT = 2'b01;

  // ------------------------------------------------------------
  // datapath
  // ------------------------------------------------------------
  always @* begin
    src = operand_in;
    res_d = operand_in;
    c_d = 1'b0;
    cw_d = 1'b0;
    fw_d = 1'b0;
    bad_d = 1'b0;
    amt = 5'h00;
    case (op_code)
      `OP_ASR_FILE, `OP_ASR_REG: begin
        cw_d = 1'b1;
        fw_d = 1'b1;
        c_d = src[0];
        if (byte_size) begin
          // a byte write into the work register keeps its own upper byte
          if (op_code == `OP_ASR_FILE && to_work_reg) begin
            res_d = {default_work_register[15:8], src[7], src[7:1]};
          end else begin
            res_d = {src[15:8], src[7], src[7:1]};
          end
        end else begin
          res_d = {src[15], src[15:1]};
        end
      end
      `OP_ASR_LIT: begin
        fw_d = 1'b1;
        res_d = asr_word(base_operand_register, {1'b0, shift_count_literal});
      end
      `OP_ASR_VAR: begin
        fw_d = 1'b1;
        // counts past 15 saturate to all sign bits
        amt = (shift_amount_reg[15:4] != 12'h000) ? 5'h10 : {1'b0, shift_amount_reg[3:0]};
        res_d = asr_word(base_operand_register, amt);
      end
      `OP_SINGLE_BIT_CLEAR_OP_FILE, `OP_SINGLE_BIT_CLEAR_OP_REG: begin
        res_d = src & ~bit_mask(bit_position_field, byte_size);
      end
      default: begin
        res_d = operand_in;
      end
    endcase
    if (is_file_op(op_code)) begin
      bad_d = !byte_size && file_addr[0];
    end
  end

  result_flags u_flags (
    .value(res_d),
    .byte_size(byte_size && op_code != `OP_ASR_LIT && op_code != `OP_ASR_VAR),
    .neg(fn),
    .zero(fz)
  );

  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      state_q <= IDLE;
      wait_q <= 8'h00;
      wait_asr_q <= 1'b0;
      wait_to_work_q <= 1'b0;
      result_q <= 16'h0000;
      write_file_q <= 1'b0;
      write_work_q <= 1'b0;
      write_dest_q <= 1'b0;
      done_q <= 1'b0;
      addr_error_q <= 1'b0;
      busy_q <= 1'b0;
      flag_n_q <= 1'b0;
      flag_z_q <= 1'b0;
      flag_c_q <= 1'b0;
      flags_we_q <= 1'b0;
      carry_we_q <= 1'b0;
    end else begin
      write_file_q <= 1'b0;
      write_work_q <= 1'b0;
      write_dest_q <= 1'b0;
      done_q <= 1'b0;
      addr_error_q <= 1'b0;
      flags_we_q <= 1'b0;
      carry_we_q <= 1'b0;
      case (state_q)
        IDLE: begin
          if (start && op_code != `OP_NONE) begin
            if (bad_d) begin
              addr_error_q <= 1'b1;
              done_q <= 1'b1;
            end else if (is_periph_sfr && SFR_WAIT > 0 && is_file_op(op_code)) begin
              // stretched access, result held until wait ends
              state_q <= WAIT;
              busy_q <= 1'b1;
              wait_q <= SFR_WAIT[7:0];
              // destination kept here, so the inputs may move during the wait
              wait_asr_q <= (op_code == `OP_ASR_FILE);
              wait_to_work_q <= to_work_reg;
              result_q <= res_d;
              flag_n_q <= fn;
              flag_z_q <= fz;
              flag_c_q <= c_d;
              flags_we_q <= 1'b0;
            end else begin
              result_q <= res_d;
              done_q <= 1'b1;
              if (op_code == `OP_ASR_FILE) begin
                write_file_q <= !to_work_reg;
                write_work_q <= to_work_reg;
              end else if (op_code == `OP_SINGLE_BIT_CLEAR_OP_FILE) begin
                write_file_q <= 1'b1;
              end else begin
                write_dest_q <= 1'b1;
              end
              flags_we_q <= fw_d;
              carry_we_q <= cw_d;
              flag_n_q <= fn;
              flag_z_q <= fz;
              flag_c_q <= c_d;
            end
          end
        end
        WAIT: begin
          wait_q <= wait_q - 8'h01;
          if (wait_q == 8'h01) begin
            state_q <= IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            // last counted cycle, the write lands here
            if (wait_asr_q && wait_to_work_q) begin
              write_work_q <= 1'b1;
            end else begin
              write_file_q <= 1'b1;
            end
            flags_we_q <= wait_asr_q;
            carry_we_q <= wait_asr_q;
          end
        end
        default: begin
          state_q <= IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end
endmodule

// >>> design/shift_clear_defines.vh
// constants for the shift and bit clear unit
//
// Summary of operation
// - bit clear zeroes selected bit only
// - bit position zero is the lsb
// - byte positions up to 7, word 15
// - word file access needs even address
// - byte size works on low 8 bits; literal and variable shifts ignore it
// - peripheral register access may take longer
`ifndef SHIFT_CLEAR_DEFINES_VH
`define SHIFT_CLEAR_DEFINES_VH
// ------------------------------------------------------------
// operation codes
// ------------------------------------------------------------
`define OP_NONE 3'h0
`define OP_ASR_FILE 3'h1
`define OP_ASR_REG 3'h2
`define OP_ASR_LIT 3'h3
`define OP_ASR_VAR 3'h4
`define OP_SINGLE_BIT_CLEAR_OP_FILE 3'h5
`define OP_SINGLE_BIT_CLEAR_OP_REG 3'h6
// ------------------------------------------------------------
// limits and timing
// ------------------------------------------------------------
`define FILE_ADDR_MAX 13'h1fff
`define WORD_ADDR_MAX 13'h1ffe
`define BYTE_BIT_MAX 4'h7
`define WORD_BIT_MAX 4'hf
`define SFR_WAIT_CYCLES 2
`endif

// >>> design/result_flags.v
// flag generator for byte or word results
`timescale 1ns/1ns
module result_flags (
  input wire [15:0] value,
  input wire byte_size,
  output wire neg,
  output wire zero
);
  assign neg = byte_size ? value[7] : value[15];
  assign zero = byte_size ? (value[7:0] == 8'h00) : (value == 16'h0000);
endmodule

// >>> bench/scu_props.sv
// assertion checker for the shift and bit clear unit
`timescale 1ns/1ns
module scu_props #(parameter int SFR_WAIT = 2) (
  input wire ref_clk,
  input wire rst,
  input wire start,
  input wire [2:0] op_code,
  input wire byte_size,
  input wire [12:0] file_addr,
  input wire is_periph_sfr,
  input wire [3:0] bit_position_field,
  input wire [15:0] operand_in,
  input wire [15:0] result_q,
  input wire write_file_q,
  input wire done_q,
  input wire addr_error_q,
  input wire busy_q,
  input wire flag_n_q,
  input wire flag_z_q,
  input wire flag_c_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // start while busy is ignored, so only this counts
  wire go = start && !busy_q;
  a_clr_word: assert property (go && op_code == 3'h6 && !byte_size |=>
    result_q == ($past(operand_in) & ~(16'h0001 << $past(bit_position_field))))
    else $error("bit clear word");
  a_clr_byte: assert property (go && op_code == 3'h6 && byte_size |=>
    result_q == ($past(operand_in) & ~(16'h0001 << $past(bit_position_field[2:0]))))
    else $error("bit clear byte");
  a_odd_word: assert property (go && op_code == 3'h5 && !byte_size && file_addr[0]
    && !is_periph_sfr |=> addr_error_q && done_q && !write_file_q) else $error("odd address");
  a_asr_byte: assert property (go && op_code == 3'h2 && byte_size |=>
    result_q == {$past(operand_in[15:8]), $past(operand_in[7]), $past(operand_in[7:1])})
    else $error("byte shift");
  a_sfr_wait: assert property (go && op_code == 3'h5 && is_periph_sfr && byte_size |=>
    busy_q && !done_q ##SFR_WAIT done_q && write_file_q) else $error("sfr stretch");
  a_asr_sign: assert property (go && op_code == 3'h2 && !byte_size |=>
    result_q == {$past(operand_in[15]), $past(operand_in[15:1])} && flag_c_q == $past(operand_in[0]))
    else $error("word shift");
  a_asr_flags: assert property (go && op_code == 3'h2 && !byte_size |=>
    flag_n_q == result_q[15] && flag_z_q == (result_q == 16'h0000)) else $error("shift flags");
  c_done: cover property (done_q && !addr_error_q);
  c_err: cover property (addr_error_q);
  c_busy: cover property (busy_q);
endmodule
bind shift_and_bit_clear_unit scu_props #(.SFR_WAIT(SFR_WAIT)) i_scu_props (.*);

// >>> bench/tb_top.sv
// random self-checking bench for the shift and bit clear unit
`timescale 1ns/1ns
module tb_top;
  localparam int W = 2;
  logic ref_clk = 0, rst = 1, start = 0, byte_size = 0, to_work_reg = 0, is_periph_sfr = 0, e;
  logic [2:0] op_code = 0;
  logic [12:0] file_addr = 0;
  logic [3:0] bit_position_field = 0, shift_count_literal = 0;
  logic [15:0] operand_in = 0, default_work_register = 0;
  logic [15:0] base_operand_register = 0, shift_amount_reg = 0;
  logic [31:0] seed = 32'h0001_4153, r;
  wire [15:0] result_q;
  wire write_file_q, write_work_q, write_dest_q, done_q, addr_error_q, busy_q;
  wire flag_n_q, flag_z_q, flag_c_q, flags_we_q, carry_we_q;
  int num_errors = 0, n_checks = 0, i, n;
  logic [15:0] x, lx;
  logic [4:0] wx, wy;
  logic fw, cw, nb;
  shift_and_bit_clear_unit #(.SFR_WAIT(W)) i_shift_and_bit_clear_unit (.*);
  always #10 ref_clk = ~ref_clk;
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [15:0] calc(input logic [2:0] o, input logic b, t, input logic [3:0] p, k,
    input logic [15:0] a, w, s, d);
    case (o)
      // a byte shift into the work register keeps that register's upper byte
      3'h1, 3'h2: calc = b ? {(((o == 3'h1) && t) ? d[15:8] : a[15:8]), a[7], a[7:1]}
        : {a[15], a[15:1]};
      3'h3: calc = $signed(w) >>> k;
      // kept apart so the sign fill is not lost to an unsigned mix
      3'h4: if (s > 16'h000f) calc = {16{w[15]}}; else calc = $signed(w) >>> s[3:0];
      default: calc = a & ~(16'h0001 << (b ? {1'b0, p[2:0]} : p));
    endcase
  endfunction
  task chk(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 0;
    for (i = 0; i < 300; i++) begin
      r = xs();
      @(posedge ref_clk);
      // first two ops are the top bit clear positions, word then byte
      start <= 1;
      op_code <= (i < 2) ? 3'h6 : 3'(r[2:0] % 6 + 1);
      byte_size <= (i < 2) ? i[0] : r[3];
      bit_position_field <= (i < 2) ? 4'hf : r[7:4];
      file_addr <= r[20:8];
      {is_periph_sfr, to_work_reg, shift_count_literal} <= r[26:21];
      shift_amount_reg <= r[27] ? r[31:16] : {12'h000, r[31:28]};
      {operand_in, base_operand_register} <= xs();
      default_work_register <= r[15:0];
      @(posedge ref_clk);
      start <= 0;
      // the plain answer already stands one step after the taking edge
      for (n = 0; n < 9; n++) begin
        #1;
        if (done_q === 1'b1) break;
        @(posedge ref_clk);
      end
      if (n == 9) begin
        num_errors++;
        break;
      end
      e = (op_code == 3'h1 || op_code == 3'h5) && !byte_size && file_addr[0];
      x = calc(op_code, byte_size, to_work_reg, bit_position_field, shift_count_literal,
        operand_in, base_operand_register, shift_amount_reg, default_work_register);
      lx = (op_code inside {3'h1, 3'h5} && is_periph_sfr) ? 16'(W) : 16'h0000;
      fw = !e && op_code inside {3'h1, 3'h2, 3'h3, 3'h4};
      cw = !e && op_code inside {3'h1, 3'h2};
      nb = byte_size && op_code inside {3'h1, 3'h2};
      wx[4] = !e && (op_code == 3'h5 || (op_code == 3'h1 && !to_work_reg));
      wx[3] = !e && op_code == 3'h1 && to_work_reg;
      wx[2] = !e && op_code inside {3'h2, 3'h3, 3'h4, 3'h6};
      wx[1:0] = {fw, cw};
      wy = {write_file_q, write_work_q, write_dest_q, flags_we_q, carry_we_q};
      chk("addr_error", {15'h0000, addr_error_q}, {15'h0000, e});
      chk("writes", {11'h000, wy}, {11'h000, wx});
      if (!e) begin
        chk("latency", 16'(n), lx);
        chk("result", result_q, x);
      end
      if (fw) begin
        chk("flag_n", {15'h0000, flag_n_q}, {15'h0000, nb ? x[7] : x[15]});
        chk("flag_z", {15'h0000, flag_z_q}, {15'h0000, nb ? !(|x[7:0]) : !(|x)});
      end
      if (cw) chk("flag_c", {15'h0000, flag_c_q}, {15'h0000, operand_in[0]});
    end
    give_verdict();
  end
endmodule
